// >>> design/uei_defs.svh
// constants for the endpoint interrupt aggregator
// assumes inclusion by the aggregator module and the testbench only
//
// Function
// [RULE1] flag sets when any endpoint source active
// [RULE2] sources: txdone, two rx banks, setup, stall
// [RULE3] request only when endpoint enable bit set
// [RULE4] flag clears by hardware when sources clear
// [RULE5] enable register: one bit per endpoint 0..6
// [RULE6] enable zero masks request, flag still tracks
// [RULE7] endpoints 2 to 4 behave like 0 and 1
// [RULE8] bit 7 reads zero; enables, flags reset zero
`ifndef UEI_DEFS_SVH
`define UEI_DEFS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define UEI_IRQ_ENABLE_INDEX  8'hC2
`define UEI_IRQ_ENABLE_ADDR   12'h308
`define UEI_FLAG_ADDR         12'h000
`define UEI_EVENT_STAT_ADDR   12'h004
`define UEI_EVENT_MASK_ADDR   12'h008

// ----------------------------------------
// field layout and resets
// ----------------------------------------
`define UEI_NUM_EP            7
`define UEI_EN_MASK           8'h7F
`define UEI_RESET_VALUE       8'h00

`endif

// >>> design/uei_pkg.sv
// types for the endpoint interrupt aggregator
// assumes uei_defs.svh is on the include path
package uei_pkg;

	// ----------------------------------------
	// per-endpoint source bundle
	// ----------------------------------------
	typedef struct packed {
		logic txComplete;
		logic rxOutBank0;
		logic rxOutBank1;
		logic setupReceived;
		logic stallCrcStatus;
	} uei_src_type;

	// ----------------------------------------
	// apb request as seen by the slave
	// ----------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} uei_apb_req_type;

endpackage : uei_pkg

// >>> design/uei_irq_aggregator.sv
// endpoint interrupt aggregator with apb register slave
// assumes endpoint status logic outside drives the sources synchronously
`timescale 1ns/10ps
`include "uei_defs.svh"

module uei_irq_aggregator #(
	parameter int NUM_EP = `UEI_NUM_EP
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// endpoint status sources
	input  wire uei_pkg::uei_src_type     epSrc [NUM_EP],
	// apb slave
	input  wire uei_pkg::uei_apb_req_type apbReq,
	output logic                          pready,
	output logic [31:0]                   prdata,
	output logic                          pslverr,
	// interrupt outputs
	output logic                          usbIrq,
	output logic                          eventIrq
);

	// ----------------------------------------
	// check clocking
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ----------------------------------------
	// apb phase decode
	// ----------------------------------------
	// setup cycle; the answer comes from flops one cycle later
	wire logic setupCyc  = apbReq.psel && !apbReq.penable;
	// completing edge: request still held and pready high
	wire logic doneCyc   = apbReq.psel && apbReq.penable && pready;
	// writes and read side effects land on the completing edge only
	wire logic wrAcc     = doneCyc && apbReq.pwrite;
	wire logic rdAcc     = doneCyc && !apbReq.pwrite;
	wire logic rdSetup   = setupCyc && !apbReq.pwrite;
	wire logic hitEnable = apbReq.paddr == `UEI_IRQ_ENABLE_ADDR;
	wire logic hitFlag   = apbReq.paddr == `UEI_FLAG_ADDR;
	wire logic hitStat   = apbReq.paddr == `UEI_EVENT_STAT_ADDR;
	wire logic hitMask   = apbReq.paddr == `UEI_EVENT_MASK_ADDR;
	wire logic mapped    = hitEnable | hitFlag | hitStat | hitMask;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] endpointIrqEnable_reg;
	logic [7:0] flag_reg;
	logic [7:0] evStat_reg;
	logic [7:0] evMask_reg;
	logic [7:0] srcAny;

	// ----------------------------------------
	// per-endpoint source or
	// ----------------------------------------
	// spare lanes stay zero so bit 7 can never flag
	for (genvar i = 0; i < 8; i++) begin : g_ep
		if (i < NUM_EP) begin : g_used
			assign srcAny[i] = |epSrc[i]; // [RULE1] [RULE2] [RULE7]

			ep_track_a: assert property (srcAny[i] |=> flag_reg[i]) // [RULE7]
				else $error("endpoint flag did not follow its source");

			ep_drop_a: assert property (!srcAny[i] |=> !flag_reg[i]) // [RULE4]
				else $error("endpoint flag held without a source");
		end else begin : g_spare
			assign srcAny[i] = 1'b0; // [RULE8]
		end
	end

	// ----------------------------------------
	// next values
	// ----------------------------------------
	// flag is a registered copy of the or; no software path clears it
	wire logic [7:0] flag_next = srcAny; // [RULE4] [RULE6]
	// rising edge of a flag is the event for the sticky status
	wire logic [7:0] rise = flag_next & ~flag_reg;
	wire logic [7:0] gated = flag_next & endpointIrqEnable_reg; // [RULE3]
	wire logic [7:0] wrByte = apbReq.pwdata[7:0] & `UEI_EN_MASK; // [RULE8]
	wire logic [7:0] endpointIrqEnable_next = (wrAcc && hitEnable) ?
		wrByte : endpointIrqEnable_reg; // [RULE5]
	// only bits that were reported get cleared, so an event that
	// lands between setup and completion stays pending
	wire logic [7:0] statClr = (rdAcc && hitStat) ? prdata[7:0] : 8'h00;
	// set wins over the read clear
	wire logic [7:0] evStat_next = (evStat_reg & ~statClr) | rise;
	wire logic [7:0] evMask_next = (wrAcc && hitMask) ?
		wrByte : evMask_reg;
	wire logic [7:0] rdSel = hitEnable ? endpointIrqEnable_reg :
		hitFlag ? flag_reg : hitStat ? evStat_reg :
		hitMask ? evMask_reg : 8'h00;
	wire logic [31:0] prdata_next = setupCyc ?
		{24'h000000, rdSel} : 32'h0000_0000;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			endpointIrqEnable_reg <= `UEI_RESET_VALUE; // [RULE8]
			flag_reg              <= `UEI_RESET_VALUE; // [RULE8]
			evStat_reg            <= `UEI_RESET_VALUE;
			evMask_reg            <= `UEI_RESET_VALUE;
			usbIrq                <= 1'b0;
			eventIrq              <= 1'b0;
			pready                <= 1'b0;
			prdata                <= 32'h0000_0000;
			pslverr               <= 1'b0;
		end else begin
			endpointIrqEnable_reg <= endpointIrqEnable_next;
			flag_reg              <= flag_next;
			evStat_reg            <= evStat_next;
			evMask_reg            <= evMask_next;
			usbIrq                <= |gated; // [RULE3]
			eventIrq              <= |(evStat_next & evMask_next);
			pready                <= setupCyc;
			prdata                <= prdata_next;
			pslverr               <= setupCyc && !mapped;
		end
	end

	// ----------------------------------------
	// flag checks
	// ----------------------------------------
	flag_set_a: assert property (srcAny[0] |=> flag_reg[0]) // [RULE1]
		else $error("flag 0 not set by source");

	flag_src_a: assert property (epSrc[1].rxOutBank1 |=> flag_reg[1]) // [RULE2]
		else $error("bank1 source did not set flag 1");

	flag_clr_a: assert property (srcAny == 8'h00 |=> flag_reg == 8'h00) // [RULE4]
		else $error("flag not cleared by hardware");

	mask_track_a: assert property (!endpointIrqEnable_reg[2] && srcAny[2]
		|=> flag_reg[2]) // [RULE6]
		else $error("disabled flag stopped tracking");

	// ----------------------------------------
	// request checks
	// ----------------------------------------
	irq_gate_a: assert property ((flag_next & endpointIrqEnable_reg)
		== 8'h00 |=> !usbIrq) // [RULE3]
		else $error("request raised without enabled flag");

	irq_raise_a: assert property ((flag_next & endpointIrqEnable_reg)
		!= 8'h00 |=> usbIrq) // [RULE3]
		else $error("enabled flag raised no request");

	ep4_irq_a: assert property (srcAny[4] && endpointIrqEnable_reg[4]
		|=> usbIrq) // [RULE7]
		else $error("endpoint 4 request missing");

	// ----------------------------------------
	// enable and flag register checks
	// ----------------------------------------
	en_write_a: assert property (wrAcc && hitEnable
		|=> endpointIrqEnable_reg ==
		($past(apbReq.pwdata[7:0]) & `UEI_EN_MASK)) // [RULE5]
		else $error("enable write not stored");

	en_hold_a: assert property (!(wrAcc && hitEnable)
		|=> $stable(endpointIrqEnable_reg)) // [RULE5]
		else $error("enable changed without a write");

	bit7_zero_a: assert property (endpointIrqEnable_reg[7] == 1'b0) // [RULE8]
		else $error("reserved enable bit set");

	en_read_a: assert property (rdSetup && hitEnable
		|=> prdata == {24'h000000, $past(endpointIrqEnable_reg)}) // [RULE8]
		else $error("enable readback wrong");

	flag_read_a: assert property (rdSetup && hitFlag
		|=> prdata[7:0] == $past(flag_reg)) // [RULE4]
		else $error("flag readback wrong");

	// ----------------------------------------
	// bus and event checks
	// ----------------------------------------
	ready_setup_a: assert property (setupCyc |=> pready)
		else $error("setup cycle not answered");

	ready_once_a: assert property (pready |=> !pready)
		else $error("ready held past the access cycle");

	bad_addr_a: assert property (setupCyc && !mapped |=> pslverr)
		else $error("unmapped address not flagged");

	stat_keep_a: assert property (rise != 8'h00
		|=> (evStat_reg & $past(rise)) == $past(rise))
		else $error("event lost against a read clear");

	ev_level_a: assert property (eventIrq == |(evStat_reg & evMask_reg))
		else $error("event request does not match status");

	// ----------------------------------------
	// coverage
	// ----------------------------------------
	irq_seen_c:  cover property (usbIrq);
	masked_c:    cover property (flag_reg[0] && !endpointIrqEnable_reg[0]);
	stat_read_c: cover property (rdAcc && hitStat && prdata[7:0] != 8'h00);
	en_write_c:  cover property (wrAcc && hitEnable);
	bad_addr_c:  cover property (pready && pslverr);

endmodule : uei_irq_aggregator

// >>> tb/uei_testbench.sv
// bench for the endpoint interrupt aggregator
// assumes uei_pkg and the design are compiled first
`timescale 1ns/10ps
`include "uei_defs.svh"
module testbench;
	logic                     clk = 1'b0;
	logic                     rst = 1'b1;
	uei_pkg::uei_src_type     epSrc [`UEI_NUM_EP];
	uei_pkg::uei_apb_req_type apbReq = '0;
	logic                     pready, pslverr, usbIrq, eventIrq, err;
	logic [31:0]              prdata, rd;
	int                       fail_count = 0;
	int                       num_checks = 0;
	always #12.5 clk = ~clk;
	uei_irq_aggregator uei_irq_aggregator_i (.clk(clk), .rst(rst),
		.epSrc(epSrc), .apbReq(apbReq), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .usbIrq(usbIrq),
		.eventIrq(eventIrq));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic conclude();
		$display("mismatches %0d checks %0d", fail_count, num_checks);
		if (fail_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// entered just after a rising edge; leaves one idle cycle
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (n == 16) begin
			fail_count++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		apbReq <= '0;
		@(posedge clk);
	endtask : apb
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		apb(1'b0, `UEI_IRQ_ENABLE_ADDR, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, `UEI_IRQ_ENABLE_ADDR, 32'hFFFFFFFF);
		apb(1'b0, `UEI_IRQ_ENABLE_ADDR, 32'h0);
		chk(rd, 32'h7F);
		apb(1'b0, 12'hFFC, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		$display("registers done");
	endtask : t_regs
	task automatic t_sources();
		for (int i = 0; i < `UEI_NUM_EP; i++) begin
			for (int j = 0; j < 5; j++) begin
				epSrc[i] <= 5'h1 << j;
				repeat (2) @(posedge clk);
				chk(usbIrq, 1'b1);
				apb(1'b0, `UEI_FLAG_ADDR, 32'h0);
				chk(rd, 32'h1 << i);
				epSrc[i] <= 5'h0;
				repeat (2) @(posedge clk);
				chk(usbIrq, 1'b0);
			end
		end
		apb(1'b1, `UEI_IRQ_ENABLE_ADDR, 32'h77);
		epSrc[3] <= 5'h1;
		repeat (2) @(posedge clk);
		chk(usbIrq, 1'b0);
		apb(1'b0, `UEI_FLAG_ADDR, 32'h0);
		chk(rd, 32'h8);
		epSrc[3] <= 5'h0;
		$display("sources done");
	endtask : t_sources
	task automatic t_event();
		apb(1'b1, `UEI_EVENT_MASK_ADDR, 32'h20);
		apb(1'b0, `UEI_EVENT_STAT_ADDR, 32'h0);
		epSrc[5] <= 5'h2;
		@(posedge clk);
		epSrc[5] <= 5'h0;
		repeat (3) @(posedge clk);
		chk(eventIrq, 1'b1);
		apb(1'b0, `UEI_EVENT_STAT_ADDR, 32'h0);
		chk(rd, 32'h20);
		chk(eventIrq, 1'b0);
		$display("events done");
	endtask : t_event
	initial begin
		for (int i = 0; i < `UEI_NUM_EP; i++)
			epSrc[i] = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_regs();
		t_sources();
		t_event();
		conclude();
	end
endmodule : testbench
